// ### pkg/slg_pkg.sv
/*
 * Shared constants of the gain-scheduled speed regulator: register indices,
 * control and status fields, reset values and fixed-point scaling.
 * Assumes a 32-bit APB master; byte address = index * 4.
 */
package slg_pkg;

	localparam int CFG_N = 20;

	// register indices
	localparam logic [4:0] IDX_CTRL      = 5'h00;
	localparam logic [4:0] IDX_SW_LOW    = 5'h01;
	localparam logic [4:0] IDX_SW_HIGH   = 5'h02;
	localparam logic [4:0] IDX_KP_HI     = 5'h03;
	localparam logic [4:0] IDX_KP_LO     = 5'h04;
	localparam logic [4:0] IDX_KI_HI     = 5'h05;
	localparam logic [4:0] IDX_KI_LO     = 5'h06;
	localparam logic [4:0] IDX_EKP_HI    = 5'h07;
	localparam logic [4:0] IDX_EKP_LO    = 5'h08;
	localparam logic [4:0] IDX_EKI_HI    = 5'h09;
	localparam logic [4:0] IDX_EKI_LO    = 5'h0A;
	localparam logic [4:0] IDX_LPF_HI    = 5'h0B;
	localparam logic [4:0] IDX_LPF_LO    = 5'h0C;
	localparam logic [4:0] IDX_CMP_LO    = 5'h0D;
	localparam logic [4:0] IDX_CMP_HI    = 5'h0E;
	localparam logic [4:0] IDX_POS_LIM   = 5'h0F;
	localparam logic [4:0] IDX_NEG_LIM   = 5'h10;
	localparam logic [4:0] IDX_FMAX      = 5'h11;
	localparam logic [4:0] IDX_EXC_RATED = 5'h12;
	localparam logic [4:0] IDX_EXC_BOOST = 5'h13;
	localparam logic [4:0] IDX_STATUS    = 5'h14;
	localparam logic [4:0] IDX_CORR      = 5'h15;

	localparam logic [15:0] CFG_RST [CFG_N] = '{
		16'h0000, 16'h0064, 16'h00C8, 16'h0200, 16'h0200,
		16'h0040, 16'h0040, 16'h0100, 16'h0100, 16'h0020,
		16'h0020, 16'h1000, 16'h1000, 16'h0000, 16'h0000,
		16'h0064, 16'h000A, 16'h1770, 16'h0400, 16'h0100
	};

	// control fields
	localparam int CTRL_RAMP_INT = 0;
	localparam int CTRL_ENC_MODE = 1;

	// status fields
	localparam int ST_REGION_LO = 0;
	localparam int ST_REGION_HI = 1;
	localparam int ST_INTEG_ACT = 2;
	localparam int ST_CLAMP_HIT = 3;
	localparam int ST_LOOP_ON   = 4;
	localparam int ST_WEIGHT_LSB = 16;

	// fixed point
	localparam logic [8:0]  W_ONE     = 9'h100;
	localparam int          W_SHIFT   = 8;
	localparam int          KI_SHIFT  = 12;
	localparam int          LPF_SHIFT = 16;
	localparam logic [15:0] PERMILLE  = 16'h03E8;

endpackage

// ### src/slg_blend.sv
/*
 * Registered linear blend between a low-region and a high-region setting.
 * Assumes weight 0..256 (256 selects hi exactly, 0 selects lo exactly).
 */
`timescale 1ns/1ps
module slg_blend
	import slg_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic signed [16:0] lo_i,
	input  wire logic signed [16:0] hi_i,
	input  wire logic        [8:0]  weight_i,
	output logic signed      [16:0] out_o
);

	logic signed [17:0] diff;
	logic signed [27:0] prod;
	logic signed [27:0] sum;

	assign diff = {hi_i[16], hi_i} - {lo_i[16], lo_i};
	assign prod = {{10{diff[17]}}, diff} * $signed({19'h00000, weight_i});
	// result always lies between lo and hi, so 17 bits never overflow
	assign sum  = {{11{lo_i[16]}}, lo_i} + (prod >>> W_SHIFT);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			out_o <= 17'h00000;
		end else begin
			out_o <= sum[16:0];
		end
	end

endmodule

// ### src/slg_speed_loop.sv
/*
 * Gain-scheduled PI speed regulator with speed estimator, feedback
 * compensation, feedback low-pass filter and clamped frequency correction.
 * Assumes freq_ref_i, speed_fb_i, running_i and at_speed_i come from logic
 * on clk_i; the two digital inputs are pins and are synchronised here.
 */
// Design decisions made here: the address map and the APB interface to the registers.
// Operation
// - above high threshold use high-speed gains
// - below low threshold use low-speed gains
// - blend gains linearly between thresholds
// - estimator has own high/low gains
// - feedback filter constant per speed region
// - ramp select one: integrate always
// - ramp select zero: integrate at constant speed
// - integral reset input forces P-only, clears
// - clamp correction to percent of fmax (limits here are permille of fmax)
// - limits locked while drive runs
// - excitation boosted low, rated high
// - low/high compensation gain on feedback
// - encoder mode input disables speed loop
`timescale 1ns/1ps
module slg_speed_loop
	import slg_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic        [31:0] paddr,
	input  wire logic        [31:0] pwdata,
	output logic             [31:0] prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic        [15:0] freq_ref_i,
	input  wire logic signed [15:0] speed_fb_i,
	input  wire logic               running_i,
	input  wire logic               at_speed_i,
	input  wire logic               di_integ_reset_i,
	input  wire logic               di_loop_disable_i,
	output logic signed      [17:0] freq_corr_o,
	output logic signed      [17:0] speed_est_o,
	output logic             [15:0] exc_cmd_o,
	output logic                    integ_active_o
);

	localparam logic signed [17:0] S18_MAX = 18'sh1FFFF;
	localparam logic signed [17:0] S18_MIN = -18'sh20000;

	function automatic logic signed [39:0] sx(input logic signed [17:0] v);
		return {{22{v[17]}}, v};
	endfunction

	function automatic logic signed [17:0] clamp(
		input logic signed [39:0] v,
		input logic signed [17:0] lo,
		input logic signed [17:0] hi
	);
		if (v > sx(hi))
			return hi;
		if (v < sx(lo))
			return lo;
		return v[17:0];
	endfunction

	logic [15:0]        cfg [CFG_N];
	logic [1:0]         irst_sync;
	logic [1:0]         ldis_sync;
	logic [8:0]         weight;
	logic signed [17:0] lim_pos;
	logic signed [17:0] lim_neg;
	logic signed [17:0] filt;
	logic signed [17:0] est;
	logic signed [17:0] est_i;
	logic signed [17:0] integ;
	logic               clamp_hit;
	logic               loop_off;

	// bus decode
	logic [4:0]  idx;
	logic        fire;
	logic        idx_cfg;
	logic        idx_lim;
	logic        mapped;
	logic        wr_refused;
	logic        cfg_we;
	logic [31:0] status;
	logic [31:0] rd_data;

	assign idx        = paddr[6:2];
	assign fire       = psel & penable & pready;
	assign idx_cfg    = (paddr[31:7] == 25'h0000000) && (idx < 5'(CFG_N));
	assign idx_lim    = (idx == IDX_POS_LIM) || (idx == IDX_NEG_LIM);
	assign mapped     = idx_cfg || (paddr[31:7] == 25'h0000000 &&
	                    (idx == IDX_STATUS || idx == IDX_CORR));
	// limit writes during a run are dropped and flagged
	assign wr_refused = pwrite & idx_lim & running_i;
	assign cfg_we     = fire & pwrite & idx_cfg & ~wr_refused;

	assign status  = {7'h00, weight, 11'h000, ~loop_off, clamp_hit,
	                  integ_active_o, weight == W_ONE, weight == 9'h000};
	assign rd_data = idx_cfg ? {16'h0000, cfg[idx]} :
	                 (mapped && idx == IDX_STATUS) ? status :
	                 mapped ? {{14{freq_corr_o[17]}}, freq_corr_o} :
	                 32'h00000000;

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			prdata  <= rd_data;
			pslverr <= psel & penable & ~pready &
			           (~mapped | (pwrite & ~idx_cfg) | wr_refused);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg <= CFG_RST;
		end else if (cfg_we) begin
			cfg[idx] <= pwdata[15:0];
		end
	end

	// pin synchronisers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irst_sync <= 2'b00;
			ldis_sync <= 2'b00;
		end else begin
			irst_sync <= {irst_sync[0], di_integ_reset_i};
			ldis_sync <= {ldis_sync[0], di_loop_disable_i};
		end
	end

	// weight from reference position between the thresholds
	logic [15:0] sw_lo;
	logic [15:0] sw_hi;
	logic [15:0] span;
	logic [23:0] quot;
	logic [8:0]  next_weight;

	assign sw_lo = cfg[IDX_SW_LOW];
	assign sw_hi = cfg[IDX_SW_HIGH];
	assign span  = sw_hi - sw_lo;
	assign quot  = (span == 16'h0000) ? 24'h000000 :
	               {freq_ref_i - sw_lo, 8'h00} / {8'h00, span};
	assign next_weight =
		(freq_ref_i >= sw_hi) ? W_ONE :
		(freq_ref_i <= sw_lo) ? 9'h000 :
		(quot > 24'(W_ONE)) ? W_ONE : quot[8:0];

	// scheduled settings
	logic signed [16:0] kp_b;
	logic signed [16:0] ki_b;
	logic signed [16:0] ekp_b;
	logic signed [16:0] eki_b;
	logic signed [16:0] lpf_b;
	logic signed [16:0] cmp_b;
	logic signed [16:0] exc_b;
	logic        [15:0] exc_sum;

	slg_blend u_kp (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({1'b0, cfg[IDX_KP_LO]}), .hi_i({1'b0, cfg[IDX_KP_HI]}),
		.weight_i(weight), .out_o(kp_b));
	slg_blend u_ki (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({1'b0, cfg[IDX_KI_LO]}), .hi_i({1'b0, cfg[IDX_KI_HI]}),
		.weight_i(weight), .out_o(ki_b));
	slg_blend u_ekp (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({1'b0, cfg[IDX_EKP_LO]}), .hi_i({1'b0, cfg[IDX_EKP_HI]}),
		.weight_i(weight), .out_o(ekp_b));
	slg_blend u_eki (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({1'b0, cfg[IDX_EKI_LO]}), .hi_i({1'b0, cfg[IDX_EKI_HI]}),
		.weight_i(weight), .out_o(eki_b));
	slg_blend u_lpf (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({1'b0, cfg[IDX_LPF_LO]}), .hi_i({1'b0, cfg[IDX_LPF_HI]}),
		.weight_i(weight), .out_o(lpf_b));
	// compensation gains are signed
	slg_blend u_cmp (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({cfg[IDX_CMP_LO][15], cfg[IDX_CMP_LO]}),
		.hi_i({cfg[IDX_CMP_HI][15], cfg[IDX_CMP_HI]}),
		.weight_i(weight), .out_o(cmp_b));

	// boost saturates rather than wrapping past full scale
	assign exc_sum = ({1'b0, cfg[IDX_EXC_RATED]} +
	                  {1'b0, cfg[IDX_EXC_BOOST]} > 17'h0FFFF) ? 16'hFFFF :
	                 cfg[IDX_EXC_RATED] + cfg[IDX_EXC_BOOST];
	slg_blend u_exc (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lo_i({1'b0, exc_sum}), .hi_i({1'b0, cfg[IDX_EXC_RATED]}),
		.weight_i(weight), .out_o(exc_b));
	assign exc_cmd_o = exc_b[15:0];

	// feedback path: compensation, filter, estimator
	logic signed [17:0] fb18;
	logic signed [17:0] fbc;
	logic signed [39:0] e_est;
	logic signed [17:0] next_filt;
	logic signed [17:0] next_est;
	logic signed [17:0] next_est_i;

	assign fb18  = {{2{speed_fb_i[15]}}, speed_fb_i};
	assign fbc   = clamp(sx(fb18) + ((sx(fb18) * sx({cmp_b[16], cmp_b}))
	               >>> W_SHIFT), S18_MIN, S18_MAX);
	assign next_filt = clamp(sx(filt) + (((sx(fbc) - sx(filt)) *
	               sx({lpf_b[16], lpf_b})) >>> LPF_SHIFT),
	               S18_MIN, S18_MAX);
	assign e_est = sx(filt) - sx(est);
	assign next_est_i = clamp(sx(est_i) + ((e_est * sx({eki_b[16], eki_b}))
	               >>> KI_SHIFT), S18_MIN, S18_MAX);
	assign next_est = clamp(sx(est_i) + ((e_est * sx({ekp_b[16], ekp_b}))
	               >>> W_SHIFT), S18_MIN, S18_MAX);

	// regulator
	logic               integ_clr;
	logic               integ_act;
	logic signed [39:0] err;
	logic signed [39:0] pterm;
	logic signed [39:0] raw_out;
	logic signed [17:0] next_integ;
	logic signed [17:0] next_corr;
	logic [31:0]        lim_pos_full;
	logic [31:0]        lim_neg_full;

	assign loop_off  = cfg[IDX_CTRL][CTRL_ENC_MODE] & ldis_sync[1];
	assign integ_clr = irst_sync[1] | loop_off;
	assign integ_act = ~integ_clr & (cfg[IDX_CTRL][CTRL_RAMP_INT] |
	                   at_speed_i);
	assign err   = sx({2'b00, freq_ref_i}) - sx(est);
	assign pterm = (err * sx({kp_b[16], kp_b})) >>> W_SHIFT;
	// integral windup stops at the output limits
	assign next_integ = integ_clr ? 18'sh00000 :
	                    integ_act ? clamp(sx(integ) + ((err *
	                    sx({ki_b[16], ki_b})) >>> KI_SHIFT), -lim_neg,
	                    lim_pos) : integ;
	assign raw_out   = pterm + sx(integ);
	assign next_corr = loop_off ? 18'sh00000 :
	                   clamp(raw_out, -lim_neg, lim_pos);

	// limits are permille of the maximum output frequency
	assign lim_pos_full = (cfg[IDX_FMAX] * cfg[IDX_POS_LIM]) / PERMILLE;
	assign lim_neg_full = (cfg[IDX_FMAX] * cfg[IDX_NEG_LIM]) / PERMILLE;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			weight         <= 9'h000;
			lim_pos        <= 18'sh00000;
			lim_neg        <= 18'sh00000;
			filt           <= 18'sh00000;
			est            <= 18'sh00000;
			est_i          <= 18'sh00000;
			integ          <= 18'sh00000;
			freq_corr_o    <= 18'sh00000;
			integ_active_o <= 1'b0;
			clamp_hit      <= 1'b0;
		end else begin
			weight         <= next_weight;
			lim_pos        <= $signed({2'b00, lim_pos_full[15:0]});
			lim_neg        <= $signed({2'b00, lim_neg_full[15:0]});
			filt           <= next_filt;
			est            <= next_est;
			est_i          <= next_est_i;
			integ          <= next_integ;
			freq_corr_o    <= next_corr;
			integ_active_o <= integ_act;
			clamp_hit      <= ~loop_off & (raw_out > sx(lim_pos) ||
			                  raw_out < -sx(lim_neg));
		end
	end

	assign speed_est_o = est;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_high_gain_pick: assert property (
		weight == W_ONE ##1 $stable(cfg[IDX_KP_HI])
		|-> kp_b == {1'b0, cfg[IDX_KP_HI]})
		else $error("high-speed gain not applied");
	a_low_gain_pick: assert property (
		weight == 9'h000 ##1 $stable(cfg[IDX_KI_LO])
		|-> ki_b == {1'b0, cfg[IDX_KI_LO]})
		else $error("low-speed integral setting not applied");
	a_blend_span: assert property (
		weight < W_ONE && weight > 9'h000 &&
		cfg[IDX_KP_LO] <= cfg[IDX_KP_HI] ##1 $stable(cfg[IDX_KP_LO]) &&
		$stable(cfg[IDX_KP_HI]) |-> kp_b >= {1'b0, cfg[IDX_KP_LO]} &&
		kp_b <= {1'b0, cfg[IDX_KP_HI]})
		else $error("blended gain outside its endpoints");
	a_est_gain_lo: assert property (
		weight == 9'h000 ##1 $stable(cfg[IDX_EKP_LO])
		|-> ekp_b == {1'b0, cfg[IDX_EKP_LO]})
		else $error("estimator low gain not applied");
	a_lpf_region: assert property (
		weight == W_ONE ##1 $stable(cfg[IDX_LPF_HI])
		|-> lpf_b == {1'b0, cfg[IDX_LPF_HI]})
		else $error("high-speed filter constant not applied");
	a_ramp_integ: assert property (
		cfg[IDX_CTRL][CTRL_RAMP_INT] && !at_speed_i
		&& !irst_sync[1] && !loop_off |=> integ_active_o)
		else $error("integral off during ramp with select one");
	a_hold_on_ramp: assert property (
		!cfg[IDX_CTRL][CTRL_RAMP_INT] &&
		!at_speed_i && !integ_clr |=> $stable(integ))
		else $error("integral moved during ramp with select zero");
	a_integ_reset: assert property (
		irst_sync[1] |=> integ == 18'sh00000 && !integ_active_o)
		else $error("integral not cleared by reset input");
	a_corr_clamp: assert property (
		1'b1 |=> freq_corr_o <= $past(lim_pos) &&
		freq_corr_o >= -$past(lim_neg))
		else $error("frequency correction beyond limit");
	a_limit_lock: assert property (
		fire && wr_refused |=> $stable(cfg[IDX_POS_LIM])
		&& $stable(cfg[IDX_NEG_LIM]))
		else $error("limit changed while running");
	a_exc_boost: assert property (
		weight == 9'h000 ##1 $stable(exc_sum)
		|-> exc_b == {1'b0, exc_sum})
		else $error("excitation boost missing at low speed");
	a_cmp_hi: assert property (
		weight == W_ONE ##1 $stable(cfg[IDX_CMP_HI])
		|-> cmp_b == {cfg[IDX_CMP_HI][15], cfg[IDX_CMP_HI]})
		else $error("high-speed compensation gain not applied");
	a_loop_disable: assert property (
		loop_off |=> freq_corr_o == 18'sh00000)
		else $error("loop still active while disabled");
	a_weight_sat: assert property (
		freq_ref_i <= sw_lo && sw_lo < sw_hi
		|=> weight == 9'h000 ##0 weight <= W_ONE)
		else $error("weight not saturated at zero");

	c_high_region: cover property (weight == W_ONE ##3 kp_b != 17'sh00000);
	c_mid_blend:   cover property (weight > 9'h000 && weight < W_ONE);
	c_refused_wr:  cover property (fire && wr_refused);
	c_clamp:       cover property (clamp_hit ##1 integ_active_o);

endmodule

// ### test/slg_drive_model.sv
/*
 * Behavioural model of the drive that sits beyond the speed regulator: the
 * modulation stage applies reference plus correction and the motor speed
 * follows it as a first-order lag.
 * Assumes one clock with the regulator; stall_i pins the shaft speed to a
 * load-imposed value so that the bench can force a known speed error.
 */
`timescale 1ns/1ps
module slg_drive_model (
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic        [15:0] freq_ref_i,
	input  wire logic signed [17:0] freq_corr_i,
	input  wire logic               stall_i,
	input  wire logic signed [15:0] stall_speed_i,
	output logic signed      [15:0] speed_o
);
	logic signed [19:0] cmd;
	logic signed [19:0] step;

	// the applied frequency is reference plus the regulator's correction
	assign cmd  = $signed({4'h0, freq_ref_i}) + 20'(freq_corr_i);
	// lag of 1/8 per cycle: slow enough that the loop sees a real error
	assign step = (cmd - 20'(speed_o)) >>> 3;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			speed_o <= 16'sh0000;
		else if (stall_i)
			speed_o <= stall_speed_i;
		else
			speed_o <= speed_o + 16'(step);
	end
endmodule

// ### test/tb.sv
/*
 * Self-checking bench for the gain-scheduled speed regulator: register
 * access over APB, region weighting, clamp, limit lock and integral modes.
 * Assumes the drive model in slg_drive_model and a 200 MHz clock.
 */
`timescale 1ns/1ps
module tb
	import slg_pkg::*;
;
	typedef struct {
		string       name;
		logic [31:0] exp;
		logic [31:0] mask;
		logic        err;
		logic        rd;
	} slg_note_t;

	localparam logic [31:0] ALL = 32'hFFFFFFFF;

	logic                     clk_i             = 1'b0;
	logic                     sys_rst_i         = 1'b1;
	logic                     psel              = 1'b0;
	logic                     penable           = 1'b0;
	logic                     pwrite            = 1'b0;
	logic              [31:0] paddr             = 32'h0;
	logic              [31:0] pwdata            = 32'h0;
	logic              [31:0] prdata;
	logic                     pready;
	logic                     pslverr;
	logic              [15:0] freq_ref_i        = 16'h0;
	logic signed       [15:0] speed_fb_i;
	logic                     running_i         = 1'b0;
	logic                     at_speed_i        = 1'b0;
	logic                     di_integ_reset_i  = 1'b0;
	logic                     di_loop_disable_i = 1'b0;
	logic signed       [17:0] freq_corr_o;
	logic signed       [17:0] speed_est_o;
	logic              [15:0] exc_cmd_o;
	logic                     integ_active_o;
	logic                     stall             = 1'b1;
	logic signed       [15:0] stall_speed       = 16'sh0000;
	logic              [31:0] d;
	int                       n_mismatch        = 0;
	int                       n_checks          = 0;
	slg_note_t                notes[$];
	slg_note_t                note;
	logic              [15:0] refs[4] = '{16'h0032, 16'h0096, 16'h00C8, 16'h00FA};
	logic              [31:0] st[4]   = '{32'h00000001, 32'h00800000,
		32'h01000002, 32'h01000002};
	logic              [15:0] ex[4]   = '{16'h0500, 16'h0480, 16'h0400, 16'h0400};
	// ctrl[5:4] at_speed[3] integ_reset[2] loop_disable[1] expected integ[0]
	logic              [5:0]  md[6]   = '{6'b000000, 6'b001001, 6'b010001,
		6'b010100, 6'b110010, 6'b010011};

	always #2.5 clk_i = ~clk_i;

	slg_speed_loop i_dut (
		.clk_i             (clk_i),
		.sys_rst_i         (sys_rst_i),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.freq_ref_i        (freq_ref_i),
		.speed_fb_i        (speed_fb_i),
		.running_i         (running_i),
		.at_speed_i        (at_speed_i),
		.di_integ_reset_i  (di_integ_reset_i),
		.di_loop_disable_i (di_loop_disable_i),
		.freq_corr_o       (freq_corr_o),
		.speed_est_o       (speed_est_o),
		.exc_cmd_o         (exc_cmd_o),
		.integ_active_o    (integ_active_o)
	);

	slg_drive_model i_drive (
		.clk_i         (clk_i),
		.sys_rst_i     (sys_rst_i),
		.freq_ref_i    (freq_ref_i),
		.freq_corr_i   (freq_corr_o),
		.stall_i       (stall),
		.stall_speed_i (stall_speed),
		.speed_o       (speed_fb_i)
	);

	task summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task run(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one transfer; the expectation is queued for the response monitor
	task apb(input logic [4:0] idx, input logic w, input logic [31:0] wd,
		input logic [31:0] exp, input logic [31:0] mask, input logic err);
		int n;
		notes.push_back('{$sformatf("reg%0d", idx), exp, mask, err, !w});
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {25'h0, idx, 2'b00};
		pwdata  <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] pready expected 1 seen 0");
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge clk_i) begin
		if (pready === 1'b1) begin
			if (notes.size() == 0) begin
				n_mismatch++;
				$display("[FAIL] response expected none seen 1");
			end else begin
				note = notes.pop_front();
				if (note.rd)
					chk(note.name, prdata & note.mask, note.exp);
				chk({note.name, "_err"}, {31'h0, pslverr}, {31'h0, note.err});
			end
		end
	end

	initial begin
		#(5ns * 20000);
		n_mismatch++;
		$display("[FAIL] watchdog expected done seen timeout");
		summarize();
	end

	initial begin
		void'($urandom(32'he777));
		run(2);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < CFG_N; i++)
			apb(5'(i), 1'b0, 32'h0, 32'(CFG_RST[i]), ALL, 1'b0);
		apb(5'h1F, 1'b0, 32'h0, 32'h0, ALL, 1'b1);
		apb(IDX_STATUS, 1'b1, 32'h1, 32'h0, 32'h0, 1'b1);
		for (int i = 1; i < CFG_N; i++) begin
			d = $urandom & 32'h0000FFFF;
			apb(5'(i), 1'b1, d, 32'h0, 32'h0, 1'b0);
			apb(5'(i), 1'b0, 32'h0, d, ALL, 1'b0);
			apb(5'(i), 1'b1, 32'(CFG_RST[i]), 32'h0, 32'h0, 1'b0);
		end
		// low switch point kept at a modest fraction of base frequency
		apb(IDX_SW_LOW, 1'b1, 32'h64, 32'h0, 32'h0, 1'b0);
		running_i <= 1'b1;
		apb(IDX_POS_LIM, 1'b1, 32'h32, 32'h0, 32'h0, 1'b1);
		apb(IDX_NEG_LIM, 1'b1, 32'h5, 32'h0, 32'h0, 1'b1);
		apb(IDX_POS_LIM, 1'b0, 32'h0, 32'h64, ALL, 1'b0);
		apb(IDX_NEG_LIM, 1'b0, 32'h0, 32'h0A, ALL, 1'b0);
		running_i <= 1'b0;
		apb(IDX_POS_LIM, 1'b1, 32'h32, 32'h0, 32'h0, 1'b0);
		for (int k = 0; k < 4; k++) begin
			freq_ref_i <= refs[k];
			run(8);
			chk("exc_cmd", 32'(exc_cmd_o), 32'(ex[k]));
			apb(IDX_STATUS, 1'b0, 32'h0, st[k],
				32'h01FF0003, 1'b0);
		end
		// integral held clear so the clamp sees proportional action only
		di_integ_reset_i <= 1'b1;
		run(16);
		chk("freq_corr_pos", 32'(freq_corr_o), 32'h0000012C);
		chk("integ_active", {31'h0, integ_active_o}, 32'h0);
		apb(IDX_CORR, 1'b0, 32'h0, 32'h0000012C, ALL, 1'b0);
		stall_speed <= 16'sh2000 + 16'($urandom & 32'h0FFF);
		freq_ref_i  <= 16'h0000;
		run(40);
		chk("freq_corr_neg", 32'(freq_corr_o), 32'hFFFFFFC4);
		// estimator must follow a large positive shaft speed
		chk("speed_est_pos", {31'h0, speed_est_o > 18'sh00100},
			32'h1);
		apb(IDX_CORR, 1'b0, 32'h0, 32'hFFFFFFC4, ALL, 1'b0);
		stall      <= 1'b0;
		freq_ref_i <= 16'h0096;
		for (int k = 0; k < 6; k++) begin
			apb(IDX_CTRL, 1'b1, 32'(md[k][5:4]), 32'h0, 32'h0, 1'b0);
			at_speed_i        <= md[k][3];
			di_integ_reset_i  <= md[k][2];
			di_loop_disable_i <= md[k][1];
			run(8);
			d = {27'h0, !(md[k][5] && md[k][1]), 1'b0, md[k][0], 2'b00};
			chk("integ_active", {31'h0, integ_active_o},
				32'(md[k][0]));
			if (d[4] == 1'b0)
				chk("freq_corr_off", 32'(freq_corr_o), 32'h0);
			apb(IDX_STATUS, 1'b0, 32'h0, d,
				32'h00000014, 1'b0);
		end
		summarize();
	end
endmodule
